// ===== rtl/drive_param_bank.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Overload limit 2 select decodes 0 off, 1 accel/const, 2 const, 3 accel/regen.
// - Overload limit 2 level takes 200..2000, or 200..1800 on large drives.
// - Overload limit 2 time takes 10..3000 in 0.01 s counts.
// - Overcurrent suppression is off for 0 and on for 1.
// - Restart level 200..2000 (1800 large) and restart time 10..3000.
// - Restart start frequency: 0 interruption, 1 maximum, 2 set frequency.
// - Modes 0 and 1 lock writes while lock input is on; 1 frees setpoint.
// - Modes 2 and 3 always lock writes; mode 3 frees the setpoint.
// - Mode 10 accepts parameter writes even while the drive runs.
// - Elapsed time threshold is a high and low word, each 0..65535.
// - Direction limit: 0 both, 1 forward only, 2 reverse only.
// - Soft start ramp select spans 0 shortest to 255 longest.
// - Display select decodes 0 to 4 as the five display sets.
module drive_param_bank
  import param_bank_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_lock_input,
  input  wire logic        drive_running,
  input  wire logic        large_rating,
  output drive_cfg_s       cfg,
  output logic      [15:0] freq_setpoint
);

  logic [2:0]  lock_sync;
  logic        lock_level;
  logic [2:0]  run_sync;
  logic        run_level;
  logic [2:0]  big_sync;
  logic        big_level;
  logic [15:0] lock_sel;
  logic        rejected;
  logic        setup;
  logic        wr_ok;
  logic        wr_go;
  logic [15:0] idx;
  logic [15:0] wval;
  logic [15:0] lvl_max;
  logic        locked;
  logic        freq_free;
  logic [31:0] next_prdata;
  logic        access;
  ovl_mode_e   ovl_mode_2;
  logic [15:0] ovl_level_2;
  logic [15:0] ovl_time_2;
  logic        oc_suppress_on;
  logic [15:0] fm_level;
  logic [15:0] fm_time;
  start_freq_e fm_start;
  logic [15:0] elapsed_hi;
  logic [15:0] elapsed_lo;
  dir_limit_e  dir_limit;
  logic [7:0]  soft_start;
  display_e    display_mode;

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // One write strobe per register keeps the address decode in one place.
  function automatic logic wr_hit(input logic        go,
                                  input logic [15:0] at,
                                  input logic [15:0] target);
    wr_hit = go && (at == target);
  endfunction : wr_hit

  // Pins are sampled through three stages; a change counts once the last
  // two agree, which keeps a glitch from flipping the lock for one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_sync  <= 3'h0;
      lock_level <= 1'b0;
    end else begin
      lock_sync <= {lock_sync[1:0], external_lock_input};
      if (lock_sync[2] == lock_sync[1]) begin
        lock_level <= lock_sync[2];
      end
    end
  end

  // The run pin may bounce at a start command, so it gets the same filter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_sync  <= 3'h0;
      run_level <= 1'b0;
    end else begin
      run_sync <= {run_sync[1:0], drive_running};
      if (run_sync[2] == run_sync[1]) begin
        run_level <= run_sync[2];
      end
    end
  end

  // The rating strap is static in practice; filtering it costs nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      big_sync  <= 3'h0;
      big_level <= 1'b0;
    end else begin
      big_sync <= {big_sync[1:0], large_rating};
      if (big_sync[2] == big_sync[1]) begin
        big_level <= big_sync[2];
      end
    end
  end

  assign setup = psel && !penable;
  assign idx   = paddr[17:2];
  assign wval  = pwdata[15:0];
  assign access = psel && penable && pready;
  // Large ratings cap the level parameters lower.
  assign lvl_max = big_level ? LEVEL_MAX_LARGE : LEVEL_MAX_SMALL;

  always_comb begin
    locked    = 1'b0;
    freq_free = 1'b0;
    unique case (lock_sel)
      16'h0000: begin
        locked = lock_level;
      end
      16'h0001: begin
        locked    = lock_level;
        freq_free = 1'b1;
      end
      16'h0002: begin
        locked = 1'b1;
      end
      16'h0003: begin
        locked    = 1'b1;
        freq_free = 1'b1;
      end
      default: begin
        locked = 1'b0;
      end
    endcase
  end

  // Range check per register; the lock selection itself is never locked.
  always_comb begin
    wr_ok = 1'b0;
    unique case (idx)
      IDX_OVL_SEL2:   wr_ok = wval <= OVL_SEL_MAX;
      IDX_OVL_LEVEL2: wr_ok = in_range(wval, LEVEL_MIN, lvl_max);
      IDX_OVL_TIME2:  wr_ok = in_range(wval, TIME_MIN, TIME_MAX);
      IDX_OC_SUPP:    wr_ok = wval <= ONOFF_MAX;
      IDX_FM_LEVEL:   wr_ok = in_range(wval, LEVEL_MIN, lvl_max);
      IDX_FM_TIME:    wr_ok = in_range(wval, TIME_MIN, TIME_MAX);
      IDX_FM_START:   wr_ok = wval <= FM_START_MAX;
      IDX_LOCK_SEL:   wr_ok = (wval <= 16'h0003) || (wval == LOCK_RUN_OK);
      IDX_ETIME_HI:   wr_ok = 1'b1;
      IDX_ETIME_LO:   wr_ok = 1'b1;
      IDX_DIR_LIMIT:  wr_ok = wval <= DIR_MAX;
      IDX_SOFT_START: wr_ok = wval <= SOFT_START_MAX;
      IDX_DISPLAY:    wr_ok = wval <= DISPLAY_MAX;
      IDX_FREQ_SET:   wr_ok = 1'b1;
      default:        wr_ok = 1'b0;
    endcase
    if (idx != IDX_LOCK_SEL && idx != IDX_FREQ_SET && locked) begin
      wr_ok = 1'b0;
    end
    if (idx == IDX_FREQ_SET && locked && !freq_free) begin
      wr_ok = 1'b0;
    end
    // While running, only mode 10 opens the parameters.
    if (run_level && lock_sel != LOCK_RUN_OK && idx != IDX_LOCK_SEL
        && idx != IDX_FREQ_SET) begin
      wr_ok = 1'b0;
    end
    if (pstrb[1:0] != 2'b11) begin
      wr_ok = 1'b0;
    end
  end

  assign wr_go = access && pwrite && wr_ok;

  // Writes commit at the access edge, with pready high; the slave never
  // inserts wait states, so a refused write simply leaves the register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_mode_2 <= OVL_OFF;
    end else if (wr_hit(wr_go, idx, IDX_OVL_SEL2)) begin
      ovl_mode_2 <= ovl_mode_e'(wval[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_level_2 <= RST_LEVEL;
    end else if (wr_hit(wr_go, idx, IDX_OVL_LEVEL2)) begin
      ovl_level_2 <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_time_2 <= RST_TIME;
    end else if (wr_hit(wr_go, idx, IDX_OVL_TIME2)) begin
      ovl_time_2 <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_suppress_on <= 1'b0;
    end else if (wr_hit(wr_go, idx, IDX_OC_SUPP)) begin
      oc_suppress_on <= wval[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_level <= RST_LEVEL;
    end else if (wr_hit(wr_go, idx, IDX_FM_LEVEL)) begin
      fm_level <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_time <= RST_TIME;
    end else if (wr_hit(wr_go, idx, IDX_FM_TIME)) begin
      fm_time <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_start <= START_INTERRUPT;
    end else if (wr_hit(wr_go, idx, IDX_FM_START)) begin
      fm_start <= start_freq_e'(wval[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_sel <= RST_ZERO;
    end else if (wr_hit(wr_go, idx, IDX_LOCK_SEL)) begin
      lock_sel <= wval;
    end
  end

  // The two halves are written apart, so a reader may see a torn value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_hi <= RST_ZERO;
    end else if (wr_hit(wr_go, idx, IDX_ETIME_HI)) begin
      elapsed_hi <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_lo <= RST_ZERO;
    end else if (wr_hit(wr_go, idx, IDX_ETIME_LO)) begin
      elapsed_lo <= wval;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_limit <= DIR_BOTH;
    end else if (wr_hit(wr_go, idx, IDX_DIR_LIMIT)) begin
      dir_limit <= dir_limit_e'(wval[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_start <= RST_ZERO[7:0];
    end else if (wr_hit(wr_go, idx, IDX_SOFT_START)) begin
      soft_start <= wval[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_mode <= DISP_COMPLETE;
    end else if (wr_hit(wr_go, idx, IDX_DISPLAY)) begin
      display_mode <= display_e'(wval[2:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_setpoint <= RST_ZERO;
    end else if (wr_hit(wr_go, idx, IDX_FREQ_SET)) begin
      freq_setpoint <= wval;
    end
  end

  // The carrier is a plain view of the registers, with no logic between.
  assign cfg = '{
    ovl_mode_2:        ovl_mode_2,
    ovl_level_2:       ovl_level_2,
    ovl_time_2:        ovl_time_2,
    oc_suppress_on:    oc_suppress_on,
    fm_level:          fm_level,
    fm_time:           fm_time,
    fm_start:          fm_start,
    elapsed_threshold: {elapsed_hi, elapsed_lo},
    dir_limit:         dir_limit,
    soft_start:        soft_start,
    display_mode:      display_mode
  };

  // Sticky reject flag; cleared by reading the status register.
  // A reject is flagged at an access edge and a clear at a setup edge, so
  // they never meet; should they, the set still wins and nothing is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rejected <= 1'b0;
    end else if (access && pwrite && !wr_ok) begin
      rejected <= 1'b1;
    end else if (setup && !pwrite && idx == IDX_STATUS) begin
      rejected <= 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (idx)
      IDX_OVL_SEL2:   next_prdata[1:0] = cfg.ovl_mode_2;
      IDX_OVL_LEVEL2: next_prdata[15:0] = cfg.ovl_level_2;
      IDX_OVL_TIME2:  next_prdata[15:0] = cfg.ovl_time_2;
      IDX_OC_SUPP:    next_prdata[0] = cfg.oc_suppress_on;
      IDX_FM_LEVEL:   next_prdata[15:0] = cfg.fm_level;
      IDX_FM_TIME:    next_prdata[15:0] = cfg.fm_time;
      IDX_FM_START:   next_prdata[1:0] = cfg.fm_start;
      IDX_LOCK_SEL:   next_prdata[15:0] = lock_sel;
      IDX_ETIME_HI:   next_prdata[15:0] = cfg.elapsed_threshold[31:16];
      IDX_ETIME_LO:   next_prdata[15:0] = cfg.elapsed_threshold[15:0];
      IDX_DIR_LIMIT:  next_prdata[1:0] = cfg.dir_limit;
      IDX_SOFT_START: next_prdata[7:0] = cfg.soft_start;
      IDX_DISPLAY:    next_prdata[2:0] = cfg.display_mode;
      IDX_FREQ_SET:   next_prdata[15:0] = freq_setpoint;
      IDX_STATUS: begin
        next_prdata[ST_LOCKED]  = locked;
        next_prdata[ST_FREQ_OK] = !locked || freq_free;
        next_prdata[ST_REJECT]  = rejected;
      end
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule : drive_param_bank

`default_nettype wire

// ===== rtl/param_bank_pkg.sv
package param_bank_pkg;

  // Register indexes; byte address is four times the index.
  localparam logic [15:0] IDX_OVL_SEL2    = 16'h1319;
  localparam logic [15:0] IDX_OVL_LEVEL2  = 16'h131A;
  localparam logic [15:0] IDX_OVL_TIME2   = 16'h131B;
  localparam logic [15:0] IDX_OC_SUPP     = 16'h131C;
  localparam logic [15:0] IDX_FM_LEVEL    = 16'h131D;
  localparam logic [15:0] IDX_FM_TIME     = 16'h131E;
  localparam logic [15:0] IDX_FM_START    = 16'h131F;
  localparam logic [15:0] IDX_LOCK_SEL    = 16'h1320;
  localparam logic [15:0] IDX_UNUSED_A    = 16'h1321;
  localparam logic [15:0] IDX_UNUSED_B    = 16'h1322;
  localparam logic [15:0] IDX_ETIME_HI    = 16'h1323;
  localparam logic [15:0] IDX_ETIME_LO    = 16'h1324;
  localparam logic [15:0] IDX_DIR_LIMIT   = 16'h1325;
  localparam logic [15:0] IDX_SOFT_START  = 16'h1326;
  localparam logic [15:0] IDX_DISPLAY     = 16'h1327;
  // Control and status registers of this bank.
  localparam logic [15:0] IDX_FREQ_SET    = 16'h1340;
  localparam logic [15:0] IDX_STATUS      = 16'h1341;

  // Range limits.
  localparam logic [15:0] OVL_SEL_MAX     = 16'h0003;
  localparam logic [15:0] LEVEL_MIN       = 16'h00C8;
  localparam logic [15:0] LEVEL_MAX_SMALL = 16'h07D0;
  localparam logic [15:0] LEVEL_MAX_LARGE = 16'h0708;
  localparam logic [15:0] TIME_MIN        = 16'h000A;
  localparam logic [15:0] TIME_MAX        = 16'h0BB8;
  localparam logic [15:0] ONOFF_MAX       = 16'h0001;
  localparam logic [15:0] FM_START_MAX    = 16'h0002;
  localparam logic [15:0] DIR_MAX         = 16'h0002;
  localparam logic [15:0] SOFT_START_MAX  = 16'h00FF;
  localparam logic [15:0] DISPLAY_MAX     = 16'h0004;
  localparam logic [15:0] LOCK_RUN_OK     = 16'h000A;

  // Reset values.
  localparam logic [15:0] RST_ZERO        = 16'h0000;
  localparam logic [15:0] RST_LEVEL       = 16'h00C8;
  localparam logic [15:0] RST_TIME        = 16'h000A;

  // Status bit positions.
  localparam int ST_LOCKED  = 0;
  localparam int ST_FREQ_OK = 1;
  localparam int ST_REJECT  = 2;

  typedef enum logic [1:0] {
    OVL_OFF       = 2'b00,
    OVL_ACC_CONST = 2'b01,
    OVL_CONST     = 2'b10,
    OVL_ACC_REGEN = 2'b11
  } ovl_mode_e;

  typedef enum logic [1:0] {
    START_INTERRUPT = 2'b00,
    START_MAX       = 2'b01,
    START_SET       = 2'b10
  } start_freq_e;

  typedef enum logic [1:0] {
    DIR_BOTH    = 2'b00,
    DIR_FORWARD = 2'b01,
    DIR_REVERSE = 2'b10
  } dir_limit_e;

  typedef enum logic [2:0] {
    DISP_COMPLETE = 3'b000,
    DISP_FUNCTION = 3'b001,
    DISP_USER     = 3'b010,
    DISP_COMPARE  = 3'b011,
    DISP_BASIC    = 3'b100
  } display_e;

  typedef struct packed {
    ovl_mode_e   ovl_mode_2;
    logic [15:0] ovl_level_2;
    logic [15:0] ovl_time_2;
    logic        oc_suppress_on;
    logic [15:0] fm_level;
    logic [15:0] fm_time;
    start_freq_e fm_start;
    logic [31:0] elapsed_threshold;
    dir_limit_e  dir_limit;
    logic [7:0]  soft_start;
    display_e    display_mode;
  } drive_cfg_s;

endpackage : param_bank_pkg

// ===== test/drive_param_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module drive_param_bank_assertions
  import param_bank_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire drive_cfg_s  cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence unused_rd_s;
    psel && !penable && !pwrite &&
      (paddr[17:2] == IDX_UNUSED_A || paddr[17:2] == IDX_UNUSED_B);
  endsequence
  rdy_after_setup_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  rdy_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  no_slverr_a: assert property (!pslverr)
    else $error("pslverr raised");
  unused_zero_a: assert property (unused_rd_s |=> prdata == 32'h0)
    else $error("unused slot read not zero");
  cfg_hold_a: assert property (!(psel && penable && pwrite) |=>
    $stable(cfg)) else $error("cfg changed without write");
  level_range_a: assert property (cfg.ovl_level_2 >= LEVEL_MIN &&
    cfg.ovl_level_2 <= LEVEL_MAX_SMALL && cfg.fm_level >= LEVEL_MIN &&
    cfg.fm_level <= LEVEL_MAX_SMALL) else $error("level out of range");
  time_range_a: assert property (cfg.ovl_time_2 >= TIME_MIN &&
    cfg.ovl_time_2 <= TIME_MAX && cfg.fm_time >= TIME_MIN &&
    cfg.fm_time <= TIME_MAX) else $error("time out of range");
  code_range_a: assert property (cfg.display_mode <= DISP_BASIC &&
    cfg.dir_limit != 2'b11 && cfg.fm_start != 2'b11)
    else $error("selector code out of range");
endmodule : drive_param_bank_assertions
bind drive_param_bank drive_param_bank_assertions chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cfg(cfg));
`default_nettype wire

// ===== test/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // Called just after a rising edge; a last transfer idles one edge so
  // that the next setup never reassigns psel in the same time step.
  task automatic xfer(input logic w, input logic [15:0] idx,
    input logic [15:0] d, input logic [3:0] s, input logic last,
    output logic [31:0] rd, output logic ok);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    ok = (pready === 1'b1);
    rd = prdata;
    penable <= 1'b0;
    if (last) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// ===== test/tb_drive_param_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_drive_param_bank
  import param_bank_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ok, rej;
  logic external_lock_input, drive_running, large_rating;
  logic [31:0] paddr, pwdata, prdata, rd, r;
  logic [3:0]  pstrb, st;
  logic [15:0] freq_setpoint, i, d;
  logic [15:0] sh [0:39];
  logic [15:0] vt [0:13] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h9,
    16'hA, 16'hC7, 16'hC8, 16'hFF, 16'h100, 16'h7D0, 16'h7D1, 16'hBB9};
  drive_cfg_s  cfg;
  int error_cnt, n_compared, seed;
  drive_param_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_lock_input(external_lock_input), .cfg(cfg),
    .drive_running(drive_running), .large_rating(large_rating),
    .freq_setpoint(freq_setpoint));
  apb_host_model host (.pclk(pclk), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb));
  always #4 pclk = ~pclk;
  function automatic logic ok_val(logic [15:0] a, logic [15:0] v);
    case (a)
      IDX_OVL_SEL2: return v <= OVL_SEL_MAX;
      IDX_OVL_LEVEL2, IDX_FM_LEVEL: return v >= LEVEL_MIN &&
        v <= (large_rating ? LEVEL_MAX_LARGE : LEVEL_MAX_SMALL);
      IDX_OVL_TIME2, IDX_FM_TIME: return v >= TIME_MIN && v <= TIME_MAX;
      IDX_OC_SUPP: return v <= ONOFF_MAX;
      IDX_FM_START, IDX_DIR_LIMIT: return v <= DIR_MAX;
      IDX_SOFT_START: return v <= SOFT_START_MAX;
      IDX_DISPLAY: return v <= DISPLAY_MAX;
      IDX_ETIME_HI, IDX_ETIME_LO, IDX_FREQ_SET: return 1'b1;
      IDX_LOCK_SEL: return v <= 16'h3 || v == LOCK_RUN_OK;
      default: return 1'b0;
    endcase
  endfunction : ok_val
  function automatic logic lk_now();
    return sh[7] == 16'h2 || sh[7] == 16'h3 ||
      (sh[7] <= 16'h1 && external_lock_input);
  endfunction : lk_now
  function automatic logic accepts(logic [15:0] a, logic [15:0] v);
    if (!ok_val(a, v) || st[1:0] != 2'b11) return 1'b0;
    if (a == IDX_LOCK_SEL) return 1'b1;
    if (a == IDX_FREQ_SET) return !lk_now() || sh[7][0];
    return !lk_now() && (!drive_running || sh[7] == LOCK_RUN_OK);
  endfunction : accepts
  function automatic logic [31:0] exp_rd(logic [15:0] a);
    if (a == IDX_STATUS)
      return {29'h0, rej, !lk_now() || sh[7][0], lk_now()};
    return {16'h0, sh[a - 16'h1319]};
  endfunction : exp_rd
  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [15:0] v, input logic last);
    host.xfer(w, a, v, st, last, rd, ok);
    if (!ok) begin
      error_cnt++;
      print_verdict();
    end else if (!w) begin
      chk(rd, exp_rd(a));
      if (a == IDX_STATUS) rej = 1'b0;
    end else if (accepts(a, v)) begin
      sh[a - 16'h1319] = v;
    end else begin
      rej = 1'b1;
    end
  endtask : acc
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] v);
    acc(1'b1, a, v, 1'b0);
    acc(1'b0, a, v, 1'b0);
    acc(1'b0, IDX_STATUS, 16'h0, 1'b1);
    chk(cfg.elapsed_threshold, {sh[10], sh[11]});
    chk({cfg.fm_level, cfg.ovl_level_2}, {sh[4], sh[1]});
    chk({cfg.fm_time, cfg.ovl_time_2}, {sh[5], sh[2]});
    chk({16'h0, cfg.soft_start, 1'b0, cfg.display_mode, cfg.ovl_mode_2,
      cfg.dir_limit}, {16'h0, sh[13][7:0], 1'b0, sh[14][2:0], sh[0][1:0],
      sh[12][1:0]});
    chk({13'h0, cfg.fm_start, cfg.oc_suppress_on, freq_setpoint},
      {13'h0, sh[6][1:0], sh[3][0], sh[39]});
  endtask : wr_rd
  initial begin
    seed = 32'h2CE0;
    pclk = 1'b0;
    presetn = 1'b0;
    external_lock_input = 1'b0;
    drive_running = 1'b0;
    large_rating = 1'b0;
    st = 4'hF;
    rej = 1'b0;
    for (int k = 0; k < 40; k++) sh[k] = RST_ZERO;
    sh[1] = RST_LEVEL;
    sh[4] = RST_LEVEL;
    sh[2] = RST_TIME;
    sh[5] = RST_TIME;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    for (int k = 0; k < 16; k++) acc(1'b0, 16'(16'h1319 + k), 16'h0, 1'b1);
    // Boundary codes hit every selector value and each small-rating range edge but the 3000 time top (only 3001); the 1800 large cap is not hit.
    for (int k = 0; k < 16; k++) begin
      foreach (vt[j]) wr_rd(16'(16'h1319 + k), vt[j]);
    end
    repeat (300) begin
      r = $random(seed);
      if (r[30:28] == 3'h0) begin
        external_lock_input <= r[25];
        drive_running <= r[26];
        large_rating <= r[27];
        repeat (5) @(posedge pclk);
      end
      i = r[4] ? IDX_FREQ_SET : 16'h1319 + {12'h0, r[3:0]};
      d = r[9] ? {4'h0, r[31:20]} : {11'h0, r[31:27]};
      st = r[8] ? 4'hF : {2'h3, r[11:10]};
      wr_rd(i, d);
    end
    print_verdict();
  end
endmodule : tb_drive_param_bank
`default_nettype wire
